// file: common/ptf_params.svh
`ifndef PTF_PARAMS_SVH
`define PTF_PARAMS_SVH
// ----------------------------------------
// Clock and time base
// ----------------------------------------
`define PTF_CLK_PERIOD_NS 8
`define PTF_US_CYCLES (1000 / `PTF_CLK_PERIOD_NS)
// ----------------------------------------
// Times in microseconds
// ----------------------------------------
`define PTF_D50_L1_US 16'h2134
`define PTF_D50_L2_US 16'h1B58
`define PTF_D50_L3_US 16'h157C
`define PTF_D50_L4_US 16'h0FA0
`define PTF_D50_L5_US 16'h09C4
`define PTF_D60_L1_US 16'h1B58
`define PTF_D60_L2_US 16'h1770
`define PTF_D60_L3_US 16'h1388
`define PTF_D60_L4_US 16'h0DAC
`define PTF_D60_L5_US 16'h07D0
`define PTF_GATE_US 16'h03E8
`define PTF_LOST_US 16'h2710
`define PTF_FREQ_SPLIT_US 16'h23F0
`define PTF_SOFT_START_US 16'h2328
`define PTF_SOFT_STEP_US 16'h000F
`define PTF_BLINK_US 18'h3_D090
// ----------------------------------------
// Knob thresholds for a 10-bit sample
// ----------------------------------------
`define PTF_KNOB_W 10
`define PTF_THR_L1 10'h040
`define PTF_THR_L2 10'h100
`define PTF_THR_L3 10'h1C0
`define PTF_THR_L4 10'h280
`define PTF_THR_L5 10'h340
`define PTF_THR_HYS 10'h010
`endif

// file: common/ptf_pkg.sv
package ptf_pkg;
	typedef logic [2:0] ptf_level_t;
	typedef enum logic [2:0] {
		PTF_STANDBY = 3'b001,
		PTF_RUN = 3'b010,
		PTF_LOST = 3'b100
	} ptf_state_t;
endpackage : ptf_pkg

// file: common/ptf_if.sv
`timescale 1ns/1ps
// Knob sample to quantiser and level back to the controller
interface ptf_if #(parameter int W = 10);
	logic [W-1:0] sample;
	ptf_pkg::ptf_level_t level;
	modport quant (input sample, output level);
	modport ctrl (output sample, input level);
endinterface : ptf_if

// file: rtl/ptf_knob_quant.sv
`timescale 1ns/1ps
`include "ptf_params.svh"
module ptf_knob_quant #(
	parameter int W = `PTF_KNOB_W
) (
	input wire logic clk,
	input wire logic srst,
	ptf_if.quant kq
);
	ptf_pkg::ptf_level_t level;
	ptf_pkg::ptf_level_t next_level;

	// Lower edge of each level, OFF below level 1
	function automatic logic [W-1:0] thr(input ptf_pkg::ptf_level_t l);
		case (l)
			3'h1: thr = W'(`PTF_THR_L1);
			3'h2: thr = W'(`PTF_THR_L2);
			3'h3: thr = W'(`PTF_THR_L3);
			3'h4: thr = W'(`PTF_THR_L4);
			3'h5: thr = W'(`PTF_THR_L5);
			default: thr = '1;
		endcase
	endfunction : thr

	// Step one level at a time; going up needs the extra hysteresis margin
	always_comb begin
		next_level = level;
		if (level < 3'h5 && {1'b0, kq.sample} >= {1'b0, thr(level + 3'h1)} + (W+1)'(`PTF_THR_HYS)) begin
			next_level = level + 3'h1;
		end else if (level != 3'h0 && kq.sample < thr(level)) begin
			next_level = level - 3'h1;
		end
	end

	// Level register, OFF after reset
	always_ff @(posedge clk) begin
		if (srst) begin
			level <= 3'h0;
		end else begin
			level <= next_level;
		end
	end

	assign kq.level = level;
endmodule : ptf_knob_quant

// file: rtl/ptf_firing_ctrl.sv
`timescale 1ns/1ps
`include "ptf_params.svh"
// Behaviour
// - Knob reading maps to five working levels, 1 least power, 5 most.
// - Level indicator shows the selected working level.
// - Clockwise knob raises level, counter-clockwise lowers it, monotonic.
// - Run indicator steadily on while firing the gate.
// - OFF knob position means standby: no gate pulses, motor unpowered.
// - Runs normally after power-up with no configuration.
// - Missing zero crossings stop firing and make the run indicator blink.
// - Firing resumes by itself when zero crossings return.
// - 50 Hz delays 8.5, 7.0, 5.5, 4.0, 2.5 ms for levels 1 to 5.
// - 60 Hz delays 7.0, 6.0, 5.0, 3.5, 2.0 ms for levels 1 to 5.
// - Gate pulse lasts 1 ms from the end of the firing delay.
// - Firing delay steps gradually toward target at start-up and level changes.
module ptf_firing_ctrl #(
	parameter int KNOB_W = `PTF_KNOB_W,
	parameter int US_CYCLES = `PTF_US_CYCLES
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic mains_zero_cross_input,
	input wire logic [KNOB_W-1:0] power_setting_knob,
	output logic triac_gate,
	output logic [4:0] level_led,
	output logic run_led,
	output logic mains_60hz
);
	// ----------------------------------------
	// Knob quantiser
	// ----------------------------------------
	ptf_if #(.W(KNOB_W)) kq ();
	ptf_pkg::ptf_level_t level;

	assign kq.sample = power_setting_knob;
	assign level = kq.level;

	ptf_knob_quant #(.W(KNOB_W)) u_quant (
		.clk(clk),
		.srst(srst),
		.kq(kq)
	);

	// ----------------------------------------
	// State
	// ----------------------------------------
	ptf_pkg::ptf_state_t state, next_state;
	logic z1, z2, z3, zstable, next_zstable;
	logic [7:0] tick_cnt, next_tick_cnt;
	logic [15:0] since_us, next_since_us;
	logic [15:0] cur_delay, next_cur_delay;
	logic [15:0] gate_us, next_gate_us;
	logic [17:0] blink_us, next_blink_us;
	logic armed, next_armed;
	logic next_gate;
	logic blink, next_blink;
	logic freq60, next_freq60;
	logic [4:0] next_level_led;
	logic next_run_led;
	logic us_tick, zc_edge, lost;
	logic [15:0] target;

	// Delay for a level at the measured frequency
	function automatic logic [15:0] delay_of(input ptf_pkg::ptf_level_t l, input logic f60);
		case (l)
			3'h1: delay_of = f60 ? `PTF_D60_L1_US : `PTF_D50_L1_US;
			3'h2: delay_of = f60 ? `PTF_D60_L2_US : `PTF_D50_L2_US;
			3'h3: delay_of = f60 ? `PTF_D60_L3_US : `PTF_D50_L3_US;
			3'h4: delay_of = f60 ? `PTF_D60_L4_US : `PTF_D50_L4_US;
			3'h5: delay_of = f60 ? `PTF_D60_L5_US : `PTF_D50_L5_US;
			default: delay_of = `PTF_SOFT_START_US;
		endcase
	endfunction : delay_of

	// ----------------------------------------
	// Zero-cross synchroniser
	// ----------------------------------------
	// Three stages; a change counts when the last two agree
	always_ff @(posedge clk) begin
		if (srst) begin
			z1 <= 1'b0;
			z2 <= 1'b0;
			z3 <= 1'b0;
		end else begin
			z1 <= mains_zero_cross_input;
			z2 <= z1;
			z3 <= z2;
		end
	end

	// Either polarity of change is a crossing
	assign zc_edge = (z2 == z3) && (z3 != zstable);
	assign us_tick = (tick_cnt == 8'(US_CYCLES - 1));
	assign lost = (since_us > `PTF_LOST_US);
	assign target = delay_of(level, freq60);

	// ----------------------------------------
	// Next-value logic
	// ----------------------------------------
	always_comb begin
		next_zstable = zc_edge ? z3 : zstable;
		next_tick_cnt = us_tick ? 8'h00 : tick_cnt + 8'h01;
		next_since_us = since_us;
		next_cur_delay = cur_delay;
		next_gate_us = gate_us;
		next_armed = armed;
		next_gate = triac_gate;
		next_freq60 = freq60;
		next_blink_us = blink_us;
		next_blink = blink;
		next_state = state;
		// Microsecond time since the last crossing, saturating
		if (zc_edge) begin
			next_since_us = 16'h0000;
			next_freq60 = (since_us < `PTF_FREQ_SPLIT_US);
		end else if (us_tick && since_us != 16'hFFFF) begin
			next_since_us = since_us + 16'h0001;
		end
		// Blink time base
		if (us_tick) begin
			if (blink_us >= `PTF_BLINK_US - 18'h0_0001) begin
				next_blink_us = 18'h0_0000;
				next_blink = ~blink;
			end else begin
				next_blink_us = blink_us + 18'h0_0001;
			end
		end
		// Mode selection
		if (level == 3'h0) begin
			next_state = ptf_pkg::PTF_STANDBY;
		end else if (lost && !zc_edge) begin
			next_state = ptf_pkg::PTF_LOST;
		end else begin
			next_state = ptf_pkg::PTF_RUN;
		end
		case (state)
			ptf_pkg::PTF_RUN: begin
				if (zc_edge) begin
					next_armed = 1'b1;
					next_gate = 1'b0;
					// Approach the target delay by small steps each half-cycle
					if (cur_delay > target + `PTF_SOFT_STEP_US) begin
						next_cur_delay = cur_delay - `PTF_SOFT_STEP_US;
					end else if (cur_delay + `PTF_SOFT_STEP_US < target) begin
						next_cur_delay = cur_delay + `PTF_SOFT_STEP_US;
					end else begin
						next_cur_delay = target;
					end
				end else if (armed && since_us >= cur_delay) begin
					next_armed = 1'b0;
					next_gate = 1'b1;
					next_gate_us = 16'h0000;
				end else if (triac_gate && us_tick) begin
					if (gate_us >= `PTF_GATE_US - 16'h0001) begin
						next_gate = 1'b0;
					end else begin
						next_gate_us = gate_us + 16'h0001;
					end
				end
			end
			default: begin
				// Standby or outage: no firing, restart soft start later
				next_armed = 1'b0;
				next_gate = 1'b0;
				next_cur_delay = `PTF_SOFT_START_US;
			end
		endcase
		if (next_state != ptf_pkg::PTF_RUN) begin
			next_gate = 1'b0;
			next_armed = 1'b0;
		end
		// Indicators
		next_level_led = 5'h00;
		if (level != 3'h0) begin
			next_level_led = 5'h01 << (level - 3'h1);
		end
		case (next_state)
			ptf_pkg::PTF_RUN: next_run_led = 1'b1;
			ptf_pkg::PTF_LOST: next_run_led = blink;
			default: next_run_led = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			state <= ptf_pkg::PTF_STANDBY;
			zstable <= 1'b0;
			tick_cnt <= 8'h00;
			since_us <= 16'hFFFF; // Treated as lost until a crossing
			cur_delay <= `PTF_SOFT_START_US;
			gate_us <= 16'h0000;
			armed <= 1'b0;
			triac_gate <= 1'b0;
			freq60 <= 1'b0;
			blink_us <= 18'h0_0000;
			blink <= 1'b0;
			level_led <= 5'h00;
			run_led <= 1'b0;
		end else begin
			state <= next_state;
			zstable <= next_zstable;
			tick_cnt <= next_tick_cnt;
			since_us <= next_since_us;
			cur_delay <= next_cur_delay;
			gate_us <= next_gate_us;
			armed <= next_armed;
			triac_gate <= next_gate;
			freq60 <= next_freq60;
			blink_us <= next_blink_us;
			blink <= next_blink;
			level_led <= next_level_led;
			run_led <= next_run_led;
		end
	end

	assign mains_60hz = freq60;
endmodule : ptf_firing_ctrl

// file: dv/ptf_firing_ctrl_sva.sv
`timescale 1ns/1ps
// ----------------------------------------
// Firing controller checks
// ----------------------------------------
module ptf_firing_ctrl_sva #(
	parameter int KNOB_W = 10,
	parameter int US_CYCLES = 125
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic mains_zero_cross_input,
	input wire logic [KNOB_W-1:0] power_setting_knob,
	input wire logic triac_gate,
	input wire logic [4:0] level_led,
	input wire logic run_led,
	input wire logic mains_60hz
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	logic zc_q;
	int since;
	int hi;
	// Clocks since the pin last moved and length of the gate pulse
	always_ff @(posedge clk) begin
		if (srst) begin
			zc_q <= mains_zero_cross_input;
			since <= 0;
			hi <= 0;
		end else begin
			zc_q <= mains_zero_cross_input;
			since <= (zc_q != mains_zero_cross_input) ? 0 : since + 1;
			hi <= triac_gate ? hi + 1 : 0;
		end
	end
	property p_onehot; $onehot0(level_led); endproperty
	a_onehot: assert property (p_onehot) else $error("level_led not one-hot");
	property p_off; (power_setting_knob < 10'h040) [*8] |-> level_led == 5'h00; endproperty
	a_off: assert property (p_off) else $error("level_led not off");
	property p_top; (power_setting_knob >= 10'h350) [*8] |-> level_led == 5'h10; endproperty
	a_top: assert property (p_top) else $error("level_led not top level");
	property p_standby; (level_led == 5'h00) [*3] |-> !triac_gate && !run_led; endproperty
	a_standby: assert property (p_standby) else $error("activity in standby");
	property p_gate_run; triac_gate |-> run_led; endproperty
	a_gate_run: assert property (p_gate_run) else $error("gate without run_led");
	property p_width; hi <= 1002 * US_CYCLES; endproperty
	a_width: assert property (p_width) else $error("gate pulse too long");
	property p_lost; since > 10010 * US_CYCLES |-> !triac_gate; endproperty
	a_lost: assert property (p_lost) else $error("gate with no crossings");
	property p_early; $rose(triac_gate) |-> since >= 2000 * US_CYCLES; endproperty
	a_early: assert property (p_early) else $error("gate fired too early");
	property p_late; $rose(triac_gate) |-> since <= 9010 * US_CYCLES; endproperty
	a_late: assert property (p_late) else $error("gate fired too late");
endmodule : ptf_firing_ctrl_sva
bind ptf_firing_ctrl ptf_firing_ctrl_sva #(.KNOB_W(KNOB_W), .US_CYCLES(US_CYCLES)) sva_i (
	.clk(clk), .srst(srst), .mains_zero_cross_input(mains_zero_cross_input),
	.power_setting_knob(power_setting_knob), .triac_gate(triac_gate),
	.level_led(level_led), .run_led(run_led), .mains_60hz(mains_60hz));

// file: dv/ptf_mains_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Zero-cross detector model
// ----------------------------------------
module ptf_mains_model (
	input wire logic clk,
	input wire logic run,
	input wire logic [15:0] half_clks,
	output logic zc
);
	int cnt = 0;
	initial zc = 1'b0;
	// Toggles at each crossing, holds its level while mains is absent
	always @(posedge clk) begin
		if (run && cnt >= half_clks - 1) begin
			zc <= ~zc;
			cnt <= 0;
		end else if (run) begin
			cnt <= cnt + 1;
		end
	end
endmodule : ptf_mains_model

// file: dv/ptf_firing_ctrl_tb_top.sv
`timescale 1ns/1ps
module ptf_firing_ctrl_tb_top;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [9:0] knob = 10'h000;
	logic run = 1'b0;
	logic [15:0] half = 16'h2710;
	logic zc, gate, run_led, hz60;
	logic [4:0] led;
	int num_errors = 0;
	int total_checks = 0;
	int d, w;
	initial forever #4 clk = ~clk;
	ptf_mains_model ptf_mains_model_i (.clk(clk), .run(run), .half_clks(half), .zc(zc));
	ptf_firing_ctrl #(.KNOB_W(10), .US_CYCLES(1)) ptf_firing_ctrl_i (.clk(clk), .srst(srst),
		.mains_zero_cross_input(zc), .power_setting_knob(knob), .triac_gate(gate),
		.level_led(led), .run_led(run_led), .mains_60hz(hz60));
	// ----------------------------------------
	// Report and compare
	// ----------------------------------------
	task automatic close_out();
		if (num_errors == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out
	task automatic chk(input string nm, input logic [4:0] exp, input logic [4:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
		total_checks++;
		if (got < lo || got > hi) begin
			num_errors++;
			$display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, got);
		end
	endtask : chk_rng
	// A wait that runs out counts as a mismatch and ends the run
	task automatic timed_out(input string nm);
		num_errors++;
		$display("ERROR %s expected event seen timeout", nm);
		close_out();
	endtask : timed_out
	// Waits for the pin to toggle
	task automatic wait_zc();
		logic z;
		int n;
		z = zc;
		n = 0;
		while (zc === z) begin
			@(negedge clk);
			n++;
			if (n > 20000) begin
				timed_out("crossing");
			end
		end
	endtask : wait_zc
	// Waits for a crossing, then times the gate delay and width
	task automatic measure();
		wait_zc();
		d = 0;
		w = 0;
		while (gate !== 1'b1) begin
			@(negedge clk);
			d++;
			if (d > 12000) begin
				timed_out("gate rise");
			end
		end
		while (gate === 1'b1) begin
			@(negedge clk);
			w++;
			if (w > 2000) begin
				timed_out("gate fall");
			end
		end
	endtask : measure
	// Counts clocks with the gate not low over a span
	task automatic count_gate(input int n);
		w = 0;
		repeat (n) begin
			@(negedge clk);
			if (gate !== 1'b0) begin
				w++;
			end
		end
	endtask : count_gate
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic sc_knob();
		logic [9:0] smp [10] = '{10'h045, 10'h050, 10'h110, 10'h1D0, 10'h290,
			10'h350, 10'h345, 10'h33F, 10'h27F, 10'h03F};
		logic [4:0] exp [10] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08,
			5'h10, 5'h10, 5'h08, 5'h04, 5'h00};
		for (int i = 0; i < 10; i++) begin
			knob = smp[i];
			repeat (10) @(negedge clk);
			chk("level_led", exp[i], led);
		end
	endtask : sc_knob
	task automatic sc_fire50();
		int prev;
		prev = 9015;
		knob = 10'h1D0;
		run = 1'b1;
		// First crossing out of outage only restarts timing
		wait_zc();
		repeat (3) begin
			measure();
			chk_rng("delay", prev - 30, prev - 10, d);
			chk_rng("width", 995, 1003, w);
			chk("run_led", 5'h01, {4'h0, run_led});
			prev = d;
		end
		chk("mains_60hz", 5'h00, {4'h0, hz60});
	endtask : sc_fire50
	// Standby at 60 Hz: no gate, dark indicators, frequency still tracked
	task automatic sc_standby();
		knob = 10'h000;
		half = 16'h208D;
		count_gate(17000);
		chk_rng("standby gate", 0, 0, w);
		chk("standby leds", 5'h00, led | {4'h0, run_led});
		chk("mains_60hz", 5'h01, {4'h0, hz60});
	endtask : sc_standby
	// Outage at 50 Hz, then automatic resume with a fresh soft start
	task automatic sc_lost();
		knob = 10'h1D0;
		run = 1'b0;
		count_gate(10500);
		chk_rng("lost gate", 0, 0, w);
		run = 1'b1;
		wait_zc();
		measure();
		chk_rng("resume delay", 8985, 9005, d);
		chk_rng("resume width", 995, 1003, w);
	endtask : sc_lost
	initial begin
		repeat (12) @(negedge clk);
		srst = 1'b0;
		repeat (2) @(negedge clk);
		chk("reset outputs", 5'h00, led | {2'h0, gate, run_led, hz60});
		sc_knob();
		sc_fire50();
		sc_lost();
		sc_standby();
		close_out();
	end
endmodule : ptf_firing_ctrl_tb_top
